//--- rtl/smc_params.svh
// constants of the smbus configuration access slave
// assumes it is included by the package and the design modules by bare name
`ifndef SMC_PARAMS_SVH
`define SMC_PARAMS_SVH

// slave address: bits 6:3 fixed, bits 2:0 from straps
`define SMC_ADDR_FIXED 4'h7

// command codes
`define SMC_CMD_WRITE 8'hbe
`define SMC_CMD_SETUP 8'hba
`define SMC_CMD_READ 8'hbd
`define SMC_CMD_PCALL 8'hcd

// byte counts
`define SMC_CNT_WRITE 8'h08
`define SMC_CNT_SETUP 8'h04
`define SMC_CNT_READ 8'h04

// operation field of command byte 1
`define SMC_OP_WRITE 3'h3
`define SMC_OP_READ 3'h4

// port select values
`define SMC_PORT_LINK 5'h01
`define SMC_PORT_VIRT 5'h10

// byte positions within a packet, address byte is 0
`define SMC_IDX_CMD 4'h1
`define SMC_IDX_CNT 4'h2
`define SMC_IDX_CB1 4'h3
`define SMC_IDX_CB2 4'h4
`define SMC_IDX_CB3 4'h5
`define SMC_IDX_CB4 4'h6
`define SMC_IDX_DATA1 4'h7
`define SMC_IDX_DATA4 4'ha
`define SMC_IDX_PEC_WR 4'hb
`define SMC_IDX_PEC_SETUP 4'h7
`define SMC_IDX_MAX 4'hf

// read return positions
`define SMC_TX_CNT 4'h0
`define SMC_TX_D1 4'h1
`define SMC_TX_D2 4'h2
`define SMC_TX_D3 4'h3
`define SMC_TX_D4 4'h4
`define SMC_TX_PEC 4'h5
`define SMC_TX_IDLE 8'hff

// crc-8 polynomial x^8 + x^2 + x + 1, initial value zero
`define SMC_CRC_POLY 8'h07
`define SMC_CRC_INIT 8'h00

`endif

//--- rtl/smc_pkg.sv
// types of the smbus configuration access slave
// assumes smc_params.svh is on the include path
package smc_pkg;
   `include "smc_params.svh"

   // gray codes along idle, receive, acknowledge, transmit
   typedef enum logic [2:0] {
      SMC_IDLE = 3'h0,
      SMC_RX = 3'h1,
      SMC_RX_ACK = 3'h3,
      SMC_TX = 3'h2,
      SMC_TX_ACK = 3'h6
   } smc_state_e;

   typedef struct packed {
      smc_state_e state;
      logic [2:0] scl_sync;
      logic [2:0] sda_sync;
      logic scl_f;
      logic sda_f;
      logic [2:0] strap_s0;
      logic [2:0] strap_s1;
      logic [2:0] strap_s2;
      logic [2:0] strap;
      logic busy;
      logic [7:0] shift;
      logic [2:0] bit_cnt;
      logic [3:0] byte_idx;
      logic rd_dir;
      logic ack_bit;
      logic ack_on;
      logic nack_rest;
      logic [7:0] cmd_code;
      logic [4:0] port_sel;
      logic [3:0] be;
      logic [11:0] addr;
      logic [31:0] wdata;
      logic wr_pend;
      logic [4:0] rd_port;
      logic [11:0] rd_addr;
      logic setup_valid;
      logic rd_armed;
      logic [31:0] rdata;
      logic rd_cap;
      logic [7:0] crc;
      logic sda_o;
      logic sda_oe;
      logic cfg_wr;
      logic cfg_rd;
      logic [3:0] cfg_port;
      logic cfg_link;
      logic cfg_virt;
      logic [11:0] cfg_addr;
      logic [3:0] cfg_be;
      logic [31:0] cfg_wdata;
   } smc_state_s;
endpackage

//--- rtl/smc_crc8.sv
// byte-wide crc-8 update step used for packet error codes
// assumes the caller registers the result; purely combinational
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_crc8
   import smc_pkg::*;
(
   input wire logic [7:0] crc_in,
   input wire logic [7:0] data_in,
   output logic [7:0] crc_out
);
   logic [7:0] stage [0:8];

   assign stage[0] = crc_in ^ data_in;

   // ********************************************************
   // one shift per data bit, msb first
   // ********************************************************
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign stage[i + 1] = stage[i][7] ? ({stage[i][6:0], 1'b0} ^ `SMC_CRC_POLY) : {stage[i][6:0], 1'b0};
   end

   assign crc_out = stage[8];
endmodule

//--- rtl/smc_cfg_slave.sv
// smbus slave giving an external master access to configuration registers
// assumes open-drain sda resolved outside; config path answers reads one cycle
// after cfg_rd_out
//
// Summary of operation
// - address is 0111 plus three strap bits
// - programmed address replaces the strap address
// - command beh performs a register write
// - bah sets up, bdh returns the register
// - process call cdh sets up and reads
// - write packets carry byte count eight
// - wrong count: nack it and rest
// - bad command: nack from that byte on
// - byte after data four is pec
// - failed pec drops write, nacks pec
// - check-disable accepts writes regardless of pec
// - byte count excludes the pec byte
// - command byte 1 bits 2:0 give operation
// - port is byte2 bits 3:0, byte3 bit7
// - port decode, 10h virtual, above reserved
// - byte enables gate written register bytes
// - dword address from byte3 and byte4
// - write data arrives most significant first
// - any config register reachable for access
// - pec checked and generated as crc-8
// - read returns count 4, data, optional pec
// - master nack ends read transmission
`timescale 1ns/1ps
`include "smc_params.svh"
module smc_cfg_slave
   import smc_pkg::*;
(
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_out,
   input wire logic [2:0] addr_strap_in,
   input wire logic addr_override_en_in,
   input wire logic [6:0] addr_override_in,
   input wire logic pec_check_dis_in,
   input wire logic iso_mode_en_in,
   output logic cfg_wr_out,
   output logic cfg_rd_out,
   output logic [3:0] cfg_port_out,
   output logic cfg_link_side_out,
   output logic cfg_virt_side_out,
   output logic [11:0] cfg_addr_out,
   output logic [3:0] cfg_be_out,
   output logic [31:0] cfg_wdata_out,
   input wire logic [31:0] cfg_rdata_in,
   output logic busy_out
);
   smc_state_s st_reg;
   smc_state_s st_next;

   logic scl_stable;
   logic sda_stable;
   logic scl_rise;
   logic scl_fall;
   logic sda_rise;
   logic sda_fall;
   logic start_det;
   logic stop_det;
   logic [7:0] rx_byte;
   logic [7:0] crc_data;
   logic [7:0] crc_upd;
   logic [6:0] my_addr;

   // ********************************************************
   // line filtering and bus conditions
   // ********************************************************
   // a change counts once the second and third stage agree
   assign scl_stable = st_reg.scl_sync[1] == st_reg.scl_sync[2];
   assign sda_stable = st_reg.sda_sync[1] == st_reg.sda_sync[2];
   assign scl_rise = scl_stable && st_reg.scl_sync[2] && !st_reg.scl_f;
   assign scl_fall = scl_stable && !st_reg.scl_sync[2] && st_reg.scl_f;
   assign sda_rise = sda_stable && st_reg.sda_sync[2] && !st_reg.sda_f;
   assign sda_fall = sda_stable && !st_reg.sda_sync[2] && st_reg.sda_f;
   assign start_det = sda_fall && st_reg.scl_f && !scl_fall;
   assign stop_det = sda_rise && st_reg.scl_f && !scl_fall;
   assign rx_byte = {st_reg.shift[6:0], st_reg.sda_f};

   // fixed upper bits, strap lower bits
   assign my_addr = addr_override_en_in ? addr_override_in : {`SMC_ADDR_FIXED, st_reg.strap};

   // crc over received and sent bytes
   assign crc_data = st_reg.rd_dir ? st_reg.shift : rx_byte;

   smc_crc8 u_crc (
      .crc_in(st_reg.crc),
      .data_in(crc_data),
      .crc_out(crc_upd)
   );

   // count, data msb first, then pec
   function automatic logic [7:0] tx_pick(input logic [3:0] idx, input logic [31:0] d, input logic [7:0] c);
      logic [7:0] b;
      b = `SMC_TX_IDLE;
      case (idx)
         `SMC_TX_CNT: b = `SMC_CNT_READ;
         `SMC_TX_D1: b = d[31:24];
         `SMC_TX_D2: b = d[23:16];
         `SMC_TX_D3: b = d[15:8];
         `SMC_TX_D4: b = d[7:0];
         `SMC_TX_PEC: b = c;
         default: b = `SMC_TX_IDLE;
      endcase
      return b;
   endfunction

   // ********************************************************
   // next state
   // ********************************************************
   always_comb begin
      logic do_commit;
      logic [3:0] pec_idx;
      logic [4:0] p;
      do_commit = 1'b0;
      pec_idx = (st_reg.cmd_code == `SMC_CMD_WRITE) ? `SMC_IDX_PEC_WR : `SMC_IDX_PEC_SETUP;
      p = st_reg.port_sel;
      st_next = st_reg;
      st_next.cfg_wr = 1'b0;
      st_next.cfg_rd = 1'b0;
      st_next.rd_cap = st_reg.cfg_rd;
      st_next.scl_sync = {st_reg.scl_sync[1:0], scl_in};
      st_next.sda_sync = {st_reg.sda_sync[1:0], sda_in};
      st_next.strap_s0 = addr_strap_in;
      st_next.strap_s1 = st_reg.strap_s0;
      st_next.strap_s2 = st_reg.strap_s1;
      st_next.strap = (~(st_reg.strap_s1 ^ st_reg.strap_s2) & st_reg.strap_s2)
                    | ((st_reg.strap_s1 ^ st_reg.strap_s2) & st_reg.strap);
      if (scl_stable) begin
         st_next.scl_f = st_reg.scl_sync[2];
      end
      if (sda_stable) begin
         st_next.sda_f = st_reg.sda_sync[2];
      end
      if (st_reg.rd_cap) begin
         st_next.rdata = cfg_rdata_in;
      end

      if (start_det) begin
         // repeated start keeps the running crc of the transaction
         if (!st_reg.busy) begin
            st_next.crc = `SMC_CRC_INIT;
         end
         do_commit = st_reg.wr_pend;
         st_next.busy = 1'b1;
         st_next.state = SMC_RX;
         st_next.bit_cnt = 3'h0;
         st_next.byte_idx = 4'h0;
         st_next.rd_dir = 1'b0;
         st_next.ack_on = 1'b0;
         st_next.nack_rest = 1'b0;
         st_next.sda_oe = 1'b0;
      end else if (stop_det) begin
         // write without pec commits at stop
         do_commit = st_reg.wr_pend;
         st_next.busy = 1'b0;
         st_next.state = SMC_IDLE;
         st_next.sda_oe = 1'b0;
         st_next.rd_dir = 1'b0;
      end else begin
         unique case (st_reg.state)
            SMC_IDLE: begin
               st_next.sda_oe = 1'b0;
            end
            SMC_RX: begin
               if (scl_rise) begin
                  st_next.shift = rx_byte;
                  st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                  if (st_reg.bit_cnt == 3'h7) begin
                     st_next.crc = crc_upd;
                     st_next.state = SMC_RX_ACK;
                     st_next.ack_bit = 1'b0;
                     if (st_reg.byte_idx != `SMC_IDX_MAX) begin
                        st_next.byte_idx = st_reg.byte_idx + 4'h1;
                     end
                     if (st_reg.byte_idx == 4'h0) begin
                        if (rx_byte[7:1] != my_addr) begin
                           st_next.state = SMC_IDLE;
                        end else if (rx_byte[0]) begin
                           if (st_reg.rd_armed) begin
                              st_next.ack_bit = 1'b1;
                              st_next.rd_dir = 1'b1;
                              st_next.rd_armed = 1'b0;
                              st_next.byte_idx = `SMC_TX_CNT;
                              st_next.shift = `SMC_CNT_READ;
                              p = st_reg.rd_port;
                              if (p <= `SMC_PORT_VIRT) begin
                                 st_next.cfg_rd = 1'b1;
                                 st_next.cfg_port = p[3:0];
                                 st_next.cfg_link = (p == `SMC_PORT_LINK) && iso_mode_en_in;
                                 st_next.cfg_virt = p == `SMC_PORT_VIRT;
                                 st_next.cfg_addr = st_reg.rd_addr;
                              end else begin
                                 st_next.rdata = 32'h0000_0000;
                              end
                           end
                        end else begin
                           st_next.ack_bit = 1'b1;
                           st_next.wr_pend = 1'b0;
                        end
                     end else if (!st_reg.nack_rest) begin
                        st_next.ack_bit = 1'b1;
                        case (st_reg.byte_idx)
                           `SMC_IDX_CMD: begin
                              st_next.cmd_code = rx_byte;
                              st_next.rd_armed = 1'b0;
                              if (rx_byte == `SMC_CMD_READ) begin
                                 st_next.rd_armed = st_reg.setup_valid;
                              end else if (rx_byte != `SMC_CMD_WRITE && rx_byte != `SMC_CMD_SETUP
                                           && rx_byte != `SMC_CMD_PCALL) begin
                                 st_next.ack_bit = 1'b0;
                                 st_next.nack_rest = 1'b1;
                              end
                           end
                           `SMC_IDX_CNT: begin
                              if ((st_reg.cmd_code == `SMC_CMD_WRITE && rx_byte != `SMC_CNT_WRITE)
                                  || (st_reg.cmd_code != `SMC_CMD_WRITE && rx_byte != `SMC_CNT_SETUP)
                                  || st_reg.cmd_code == `SMC_CMD_READ) begin
                                 st_next.ack_bit = 1'b0;
                                 st_next.nack_rest = 1'b1;
                              end
                           end
                           `SMC_IDX_CB1: begin
                              if ((st_reg.cmd_code == `SMC_CMD_WRITE) ? (rx_byte[2:0] != `SMC_OP_WRITE)
                                                                      : (rx_byte[2:0] != `SMC_OP_READ)) begin
                                 st_next.ack_bit = 1'b0;
                                 st_next.nack_rest = 1'b1;
                              end
                           end
                           // port select split over two bytes
                           `SMC_IDX_CB2: st_next.port_sel[4:1] = rx_byte[3:0];
                           `SMC_IDX_CB3: begin
                              st_next.port_sel[0] = rx_byte[7];
                              st_next.be = rx_byte[5:2];
                              st_next.addr[11:10] = rx_byte[1:0];
                           end
                           `SMC_IDX_CB4: begin
                              st_next.addr[9:0] = {rx_byte, 2'b00};
                              if (st_reg.cmd_code != `SMC_CMD_WRITE) begin
                                 st_next.rd_port = st_reg.port_sel;
                                 st_next.rd_addr = {st_reg.addr[11:10], rx_byte, 2'b00};
                                 st_next.setup_valid = 1'b1;
                                 st_next.rd_armed = st_reg.cmd_code == `SMC_CMD_PCALL;
                              end
                           end
                           default: begin
                              if (st_reg.byte_idx == pec_idx) begin
                                 if (pec_check_dis_in || rx_byte == st_reg.crc) begin
                                    do_commit = st_reg.wr_pend;
                                 end else begin
                                    st_next.ack_bit = 1'b0;
                                    st_next.nack_rest = 1'b1;
                                    st_next.setup_valid = st_reg.cmd_code == `SMC_CMD_WRITE && st_reg.setup_valid;
                                    st_next.rd_armed = 1'b0;
                                 end
                                 st_next.wr_pend = 1'b0;
                              end else if (st_reg.byte_idx > pec_idx) begin
                                 st_next.ack_bit = 1'b0;
                                 st_next.nack_rest = 1'b1;
                              end else begin
                                 // first data byte lands in bits 31:24
                                 st_next.wdata = {st_reg.wdata[23:0], rx_byte};
                                 st_next.wr_pend = st_reg.byte_idx == `SMC_IDX_DATA4;
                              end
                           end
                        endcase
                     end
                  end
               end
            end
            SMC_RX_ACK: begin
               if (scl_fall) begin
                  if (!st_reg.ack_on) begin
                     st_next.ack_on = 1'b1;
                     st_next.sda_oe = st_reg.ack_bit;
                  end else begin
                     st_next.ack_on = 1'b0;
                     st_next.sda_oe = 1'b0;
                     st_next.bit_cnt = 3'h0;
                     st_next.state = SMC_RX;
                     if (st_reg.rd_dir) begin
                        st_next.sda_oe = !st_reg.shift[7];
                        st_next.bit_cnt = 3'h1;
                        st_next.state = SMC_TX;
                     end
                  end
               end
            end
            SMC_TX: begin
               if (scl_fall) begin
                  if (st_reg.bit_cnt == 3'h0) begin
                     st_next.sda_oe = 1'b0;
                     st_next.crc = crc_upd;
                     st_next.ack_on = 1'b0;
                     st_next.state = SMC_TX_ACK;
                  end else begin
                     st_next.sda_oe = !st_reg.shift[~st_reg.bit_cnt];
                     st_next.bit_cnt = st_reg.bit_cnt + 3'h1;
                  end
               end
            end
            SMC_TX_ACK: begin
               if (scl_rise) begin
                  if (st_reg.sda_f) begin
                     st_next.state = SMC_IDLE;
                     st_next.rd_dir = 1'b0;
                  end else begin
                     st_next.ack_on = 1'b1;
                     st_next.byte_idx = st_reg.byte_idx + 4'h1;
                     st_next.shift = tx_pick(st_reg.byte_idx + 4'h1, st_reg.rdata, st_reg.crc);
                  end
               end else if (scl_fall && st_reg.ack_on) begin
                  st_next.ack_on = 1'b0;
                  st_next.sda_oe = !st_reg.shift[7];
                  st_next.bit_cnt = 3'h1;
                  st_next.state = SMC_TX;
               end
            end
         endcase
      end

      // the register the port and address name, only for ports 10h and below
      if (do_commit) begin
         st_next.wr_pend = 1'b0;
         p = st_reg.port_sel;
         if (p <= `SMC_PORT_VIRT) begin
            st_next.cfg_wr = 1'b1;
            st_next.cfg_port = p[3:0];
            st_next.cfg_link = (p == `SMC_PORT_LINK) && iso_mode_en_in;
            st_next.cfg_virt = p == `SMC_PORT_VIRT;
            st_next.cfg_addr = st_reg.addr;
            st_next.cfg_be = st_reg.be;
            st_next.cfg_wdata = st_reg.wdata;
         end
      end
   end

   // ********************************************************
   // state register
   // ********************************************************
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '0;
         st_reg.scl_sync <= 3'h7;
         st_reg.sda_sync <= 3'h7;
         st_reg.scl_f <= 1'b1;
         st_reg.sda_f <= 1'b1;
         st_reg.state <= SMC_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sda_out = st_reg.sda_o;
   assign sda_oe_out = st_reg.sda_oe;
   assign cfg_wr_out = st_reg.cfg_wr;
   assign cfg_rd_out = st_reg.cfg_rd;
   assign cfg_port_out = st_reg.cfg_port;
   assign cfg_link_side_out = st_reg.cfg_link;
   assign cfg_virt_side_out = st_reg.cfg_virt;
   assign cfg_addr_out = st_reg.cfg_addr;
   assign cfg_be_out = st_reg.cfg_be;
   assign cfg_wdata_out = st_reg.cfg_wdata;
   assign busy_out = st_reg.busy;
endmodule

//--- dv/smc_cfg_props.sv
// port checks for the smbus config access slave
// assumes one clock domain and a reset that clears all strobes
`timescale 1ns/1ps
module smc_cfg_props (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic sda_oe_out,
   input wire logic iso_mode_en_in,
   input wire logic cfg_wr_out,
   input wire logic cfg_rd_out,
   input wire logic [3:0] cfg_port_out,
   input wire logic cfg_link_side_out,
   input wire logic cfg_virt_side_out,
   input wire logic [11:0] cfg_addr_out,
   input wire logic busy_out
);
   // ****************
   // checks
   // ****************
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   a_wr_once: assert property (cfg_wr_out |=> !cfg_wr_out) else $error("write strobe too long");
   a_rd_once: assert property (cfg_rd_out |=> !cfg_rd_out) else $error("read strobe too long");
   a_one_op: assert property (!(cfg_wr_out && cfg_rd_out)) else $error("read and write together");
   a_rd_busy: assert property (cfg_rd_out |-> busy_out) else $error("read outside a transaction");
   a_addr_align: assert property ((cfg_wr_out || cfg_rd_out) |-> cfg_addr_out[1:0] == 2'h0)
      else $error("address not dword aligned");
   a_side_excl: assert property (cfg_wr_out |-> !(cfg_link_side_out && cfg_virt_side_out))
      else $error("both port sides selected");
   a_virt_port: assert property (cfg_wr_out && cfg_virt_side_out |-> cfg_port_out == 4'h0)
      else $error("virtual side with nonzero port");
   a_link_iso: assert property (cfg_wr_out && cfg_link_side_out |-> iso_mode_en_in)
      else $error("link side without isolation mode");
   a_ack_hold: assert property ($rose(sda_oe_out) |=> sda_oe_out [*3]) else $error("sda pull too short");
   a_idle_free: assert property (!busy_out |-> !sda_oe_out) else $error("sda pulled while idle");
   c_wr: cover property (cfg_wr_out);
   c_rd: cover property (cfg_rd_out);
   c_virt: cover property (cfg_wr_out && cfg_virt_side_out);
endmodule
bind smc_cfg_slave smc_cfg_props u_props (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .sda_oe_out(sda_oe_out),
   .iso_mode_en_in(iso_mode_en_in), .cfg_wr_out(cfg_wr_out), .cfg_rd_out(cfg_rd_out), .cfg_port_out(cfg_port_out),
   .cfg_link_side_out(cfg_link_side_out), .cfg_virt_side_out(cfg_virt_side_out), .cfg_addr_out(cfg_addr_out),
   .busy_out(busy_out));

//--- dv/smc_master_model.sv
// smbus master model, one bit per 400 ns
// assumes the slave pulls sda low through an active-high enable
`timescale 1ns/1ps
module smc_master_model (
   input wire logic clk_sys_in,
   input wire logic sda_oe_in,
   input wire logic sda_val_in,
   output logic scl_out,
   output logic sda_out
);
   // ****************
   // link driver
   // ****************
   logic sda_drv = 1'b1;
   initial scl_out = 1'b1;
   // open drain, pulled up when released; an enabled pull bites only if the slave drives low
   assign sda_out = sda_drv & (~sda_oe_in | sda_val_in);
   task automatic clks(input int n);
      repeat (n) @(negedge clk_sys_in);
   endtask
   // data moves late in scl low, after the slave has let go
   task automatic bit_io(input logic v, output logic s);
      clks(5);
      sda_drv = v;
      clks(1);
      scl_out = 1'b1;
      clks(1);
      s = sda_out;
      clks(1);
      scl_out = 1'b0;
   endtask
   task automatic start_c;
      clks(5);
      sda_drv = 1'b1;
      clks(1);
      scl_out = 1'b1;
      clks(2);
      sda_drv = 1'b0;
      clks(2);
      scl_out = 1'b0;
   endtask
   task automatic stop_c;
      clks(5);
      sda_drv = 1'b0;
      clks(1);
      scl_out = 1'b1;
      clks(2);
      sda_drv = 1'b1;
      clks(4);
   endtask
   task automatic wbyte(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(b[i], s);
      bit_io(1'b1, s);
      ack = !s;
   endtask
   task automatic rbyte(input logic more, output logic [7:0] b);
      logic s;
      for (int i = 7; i >= 0; i--) bit_io(1'b1, b[i]);
      bit_io(!more, s);
   endtask
endmodule

//--- dv/tb_smc_cfg_slave.sv
// self-checking bench for the smbus config access slave
// assumes the master model drives the link; config reads answer a pattern
`timescale 1ns/1ps
module tb_smc_cfg_slave;
   logic clk_sys_in, nrst_in, ovr_en, pec_dis, iso, scl, sda, sda_oe, cfg_wr, cfg_rd, link, virt, busy, ack, sdo;
   logic [6:0] sadr;
   logic [3:0] port, be;
   logic [11:0] addr;
   logic [31:0] wdata, rdata;
   logic [7:0] crc;
   logic [7:0] pkt[$];
   int fail_count, check_count, wcnt, cyc;
   // ****************
   // harness
   // ****************
   assign rdata = {addr, 3'h0, virt, port, 12'h0};
   smc_cfg_slave DUT (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda), .sda_out(sdo),
      .sda_oe_out(sda_oe), .addr_strap_in(3'h5), .addr_override_en_in(ovr_en), .addr_override_in(7'h2a),
      .pec_check_dis_in(pec_dis), .iso_mode_en_in(iso), .cfg_wr_out(cfg_wr), .cfg_rd_out(cfg_rd),
      .cfg_port_out(port), .cfg_link_side_out(link), .cfg_virt_side_out(virt), .cfg_addr_out(addr),
      .cfg_be_out(be), .cfg_wdata_out(wdata), .cfg_rdata_in(rdata), .busy_out(busy));
   smc_master_model m (.clk_sys_in(clk_sys_in), .sda_oe_in(sda_oe), .sda_val_in(sdo), .scl_out(scl), .sda_out(sda));
   initial begin
      clk_sys_in = 1'b0;
      forever #25 clk_sys_in = ~clk_sys_in;
   end
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cfg_wr === 1'b1) wcnt++;
      // whole run needs about 10800 cycles
      if (cyc == 40000) begin
         fail_count++;
         finish_test;
      end
   end
   function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
      logic [7:0] x;
      x = c ^ d;
      repeat (8) x = x[7] ? {x[6:0], 1'b0} ^ 8'h07 : {x[6:0], 1'b0};
      return x;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      check_count++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   // pec 0 none, 1 good, 2 bad; nk is first refused byte or -1
   task automatic send(input int pec, output int nk);
      crc = 8'h00;
      nk = -1;
      foreach (pkt[i]) crc = crc8(crc, pkt[i]);
      if (pec > 0) pkt.push_back(pec == 1 ? crc : ~crc);
      m.start_c();
      foreach (pkt[i]) begin
         m.wbyte(pkt[i], ack);
         if (ack !== 1'b1 && nk < 0) nk = i;
      end
   endtask
   task automatic do_wr(logic [7:0] cmd, cnt, c1, logic [4:0] p, logic [3:0] b, logic [11:0] a, logic [31:0] d,
         int pec, int exp);
      int nk, w0;
      logic ok;
      w0 = wcnt;
      ok = exp < 0 && p <= 5'h10;
      pkt = '{{sadr, 1'b0}, cmd, cnt, c1, {4'h0, p[4:1]}, {p[0], 1'b0, b, a[11:10]}, a[9:2], d[31:24], d[23:16],
         d[15:8], d[7:0]};
      send(pec, nk);
      m.stop_c();
      m.clks(8);
      chk("refused byte", exp, nk);
      chk("write count", ok, wcnt - w0);
      if (ok) begin
         chk("address", {a[11:2], 2'h0}, addr);
         chk("enables", b, be);
         chk("data", d, wdata);
         chk("port", p == 5'h10 ? 4'h0 : p[3:0], port);
         chk("sides", {iso && p == 5'h01, p == 5'h10}, {link, virt});
      end
      $display("write test %h %h done", cmd, p);
   endtask
   task automatic do_rd(logic [7:0] cmd, logic [4:0] p, logic [11:0] a, int n);
      int nk;
      logic [7:0] b;
      logic [31:0] e;
      e = p > 5'h10 ? 32'h0 : {a[11:2], 2'h0, 3'h0, p == 5'h10, p == 5'h10 ? 4'h0 : p[3:0], 12'h0};
      pkt = '{{sadr, 1'b0}, cmd, 8'h04, 8'h04, {4'h0, p[4:1]}, {p[0], 1'b0, 4'hf, a[11:10]}, a[9:2]};
      send(0, nk);
      chk("setup refused", -1, nk);
      if (cmd == 8'hba) begin
         m.stop_c();
         pkt = '{{sadr, 1'b0}, 8'hbd};
         send(0, nk);
         chk("read command refused", -1, nk);
      end
      crc = crc8(crc, {sadr, 1'b1});
      m.start_c();
      m.wbyte({sadr, 1'b1}, ack);
      chk("read address ack", 1, ack);
      for (int i = 0; i < n; i++) begin
         m.rbyte(i < n - 1, b);
         chk("read byte", i == 0 ? 8'h04 : i < 5 ? e[39 - 8 * i -: 8] : crc, b);
         crc = crc8(crc, b);
      end
      m.stop_c();
      $display("read test %h %h done", cmd, p);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // ****************
   // tests
   // ****************
   initial begin
      nrst_in = 1'b0;
      ovr_en = 1'b0;
      pec_dis = 1'b0;
      iso = 1'b0;
      sadr = 7'h3d;
      repeat (16) @(negedge clk_sys_in);
      nrst_in = 1'b1;
      m.clks(8);
      do_wr(8'hbe, 8'h08, 8'h03, 5'h01, 4'h5, 12'h8f8, 32'h12345678, 0, -1);
      do_wr(8'hbe, 8'h07, 8'h03, 5'h01, 4'hf, 12'h8f8, 32'h1, 0, 2);
      do_wr(8'hbf, 8'h08, 8'h03, 5'h01, 4'hf, 12'h8f8, 32'h2, 0, 1);
      do_wr(8'hbe, 8'h08, 8'h03, 5'h0f, 4'hf, 12'h004, 32'h89abcdef, 1, -1);
      do_wr(8'hbe, 8'h08, 8'h03, 5'h0e, 4'h3, 12'h008, 32'h3, 2, 11);
      pec_dis = 1'b1;
      do_wr(8'hbe, 8'h08, 8'h03, 5'h0e, 4'h8, 12'h00c, 32'h4, 2, -1);
      pec_dis = 1'b0;
      iso = 1'b1;
      ovr_en = 1'b1;
      sadr = 7'h2a;
      do_wr(8'hbe, 8'h08, 8'hfb, 5'h01, 4'ha, 12'h400, 32'h5, 0, -1);
      do_wr(8'hbe, 8'h08, 8'h03, 5'h10, 4'hf, 12'hffc, 32'h6, 0, -1);
      do_wr(8'hbe, 8'h08, 8'h03, 5'h11, 4'hf, 12'h010, 32'h7, 0, -1);
      iso = 1'b0;
      do_rd(8'hba, 5'h02, 12'h3fc, 6);
      do_rd(8'hcd, 5'h10, 12'hc10, 5);
      do_rd(8'hcd, 5'h11, 12'h010, 5);
      finish_test;
   end
endmodule
